//--- verilog/idacu_pkg.sv
// Package: register map, field layout and reset values of the DAC update control
package idacu_pkg;

  // ==========================================================
  // Register byte addresses; control sits at four times its index
  localparam logic [9:0]  IDACU_CONTROL_INDEX = 10'h0b9;
  localparam logic [11:0] IDACU_ADDR_CONTROL  = {IDACU_CONTROL_INDEX, 2'b00};
  localparam logic [11:0] IDACU_ADDR_HIGH     = 12'h2e8;
  localparam logic [11:0] IDACU_ADDR_LOW      = 12'h2ec;
  localparam logic [11:0] IDACU_ADDR_BIAS     = 12'h2f0;
  localparam logic [11:0] IDACU_ADDR_OUTPUT   = 12'h2f4;

  // ==========================================================
  // Control register fields
  localparam int          IDACU_ENABLE_BIT  = 7;
  localparam int          IDACU_SOURCE_HI   = 6;
  localparam int          IDACU_SOURCE_LO   = 4;
  localparam int          IDACU_SCALE_HI    = 1;
  localparam int          IDACU_SCALE_LO    = 0;
  localparam logic [7:0]  IDACU_CONTROL_MASK  = 8'hf3;
  localparam logic [7:0]  IDACU_CONTROL_RESET = 8'h72;
  localparam logic [7:0]  IDACU_DATA_RESET    = 8'h00;
  localparam logic [9:0]  IDACU_LATCH_RESET   = 10'h000;

  // ==========================================================
  // Update source codes
  localparam logic [2:0] IDACU_SRC_TIMER0  = 3'h0;
  localparam logic [2:0] IDACU_SRC_TIMER1  = 3'h1;
  localparam logic [2:0] IDACU_SRC_TIMER2  = 3'h2;
  localparam logic [2:0] IDACU_SRC_TIMER3  = 3'h3;
  localparam logic [2:0] IDACU_SRC_RISE    = 3'h4;
  localparam logic [2:0] IDACU_SRC_FALL    = 3'h5;
  localparam logic [2:0] IDACU_SRC_BOTH    = 3'h6;
  localparam logic [2:0] IDACU_SRC_ONWRITE = 3'h7;

  // Full-scale range decode
  typedef enum logic [2:0] {
    IDACU_FS_HALF = 3'b001,
    IDACU_FS_ONE  = 3'b010,
    IDACU_FS_TWO  = 3'b100
  } idacu_fullscale_t;

endpackage

//--- verilog/idacu_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module idacu_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage_one;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // idacu_sync

//--- verilog/idacu_edge.sv
// Edge detector on a synchronised level, selectable edge kind
`timescale 1ns/10ps
module idacu_edge (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Level and selection
  input  wire logic level_in,
  input  wire logic want_rise,
  input  wire logic want_fall,
  output logic      edge_hit
);
  logic level_prev;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_in;
    end
  end

  always_comb begin
    edge_hit = (want_rise && level_in && !level_prev) || (want_fall && !level_in && level_prev);
  end
endmodule // idacu_edge

//--- verilog/idacu_top.sv
// DAC update control: AHB-Lite registers, update scheduling, pin and bias control
//
// Functional notes
// [RULE1] Enabled: drivers and pull-up off, pin analog
// [RULE2] Disabled: pin acts as plain GPIO
// [RULE3] Enabled DAC turns bias generator on
// [RULE4] Code 111: high-byte write updates latch
// [RULE5] Low-byte write held until high write
// [RULE6] Software writes low byte then high
// [RULE7] 8-bit use: preload low, write high
// [RULE8] Codes 000-011: wait for timer overflow
// [RULE9] Codes 100-110: wait for strobe edge
// [RULE10] Event copies both bytes in one step
// [RULE11] Word left-justified: high 7-0, low 7-6
// [RULE12] Full-scale code: 0.5, 1.0, 2.0 mA
// [RULE13] Control resets to 0x72
// [RULE14] Software sets port0 skip bit 1
// [RULE15] Bias on by user or software bit
// [RULE16] 100 rise, 101 fall, 110 both
// [RULE17] Control bits 3-2 read zero
`timescale 1ns/10ps
module idacu_top
#(
  parameter int DATA_WIDTH = 10
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Update events
  input  wire logic [3:0]             timer_overflow,
  input  wire logic                   external_convert_strobe,
  // Other analog users of the bias generator
  input  wire logic                   bias_user_request,
  // Shared pin control
  input  wire logic                   gpio_out,
  input  wire logic                   gpio_oe_b,
  input  wire logic                   gpio_pullup,
  output logic                        pin_out,
  output logic                        pin_oe_b,
  output logic                        pin_pullup,
  output logic                        pin_analog_connect,
  // Converter controls
  output logic      [DATA_WIDTH-1:0]  dac_latch,
  output logic                        dac_power,
  output logic                        bias_on,
  output logic      [2:0]             dac_fullscale_onehot
);
  import idacu_pkg::*;

  // ==========================================================
  // Registers and wires
  logic [7:0]       dac_control;
  logic [7:0]       dac_data_high;
  logic [7:0]       dac_data_low;
  logic             bias_generator_enable;
  logic             dac_enable;
  logic [2:0]       dac_update_source;
  logic [1:0]       dac_fullscale_select;
  logic             ph_write;
  logic             ph_read;
  logic [11:0]      ph_addr;
  logic             addr_ok;
  logic             wr_control;
  logic             wr_high;
  logic             wr_low;
  logic             wr_bias;
  logic             strobe_sync;
  logic             strobe_edge;
  logic             timer_sync_0;
  logic             timer_sync_1;
  logic             timer_sync_2;
  logic             timer_sync_3;
  logic             update_now;
  logic [31:0]      next_rdata;
  logic [DATA_WIDTH-1:0] next_word;
  idacu_fullscale_t next_fullscale;
  logic             onwrite_mode;
  logic             load_latch;
  logic             want_rise;
  logic             want_fall;

  assign dac_enable           = dac_control[IDACU_ENABLE_BIT];
  assign dac_update_source    = dac_control[IDACU_SOURCE_HI:IDACU_SOURCE_LO];
  assign dac_fullscale_select = dac_control[IDACU_SCALE_HI:IDACU_SCALE_LO];
  assign onwrite_mode         = (dac_update_source == IDACU_SRC_ONWRITE);

  // ==========================================================
  // AHB-Lite address phase capture; zero wait states for writes, one for reads
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_write <= 1'b0;
      ph_read  <= 1'b0;
      ph_addr  <= 12'h000;
    end else if (hready) begin
      ph_write <= hsel && htrans[1] && hwrite;
      ph_read  <= hsel && htrans[1] && !hwrite;
      ph_addr  <= haddr[11:0];
    end
  end

  always_comb begin
    addr_ok = (ph_addr == IDACU_ADDR_CONTROL) || (ph_addr == IDACU_ADDR_HIGH) ||
              (ph_addr == IDACU_ADDR_LOW) || (ph_addr == IDACU_ADDR_BIAS) ||
              (ph_addr == IDACU_ADDR_OUTPUT);
  end

  assign wr_control = ph_write && (ph_addr == IDACU_ADDR_CONTROL);
  assign wr_high    = ph_write && (ph_addr == IDACU_ADDR_HIGH);
  assign wr_low     = ph_write && (ph_addr == IDACU_ADDR_LOW);
  assign wr_bias    = ph_write && (ph_addr == IDACU_ADDR_BIAS);

  // Reads take one wait state so read data leave a register; writes never stall
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_control <= IDACU_CONTROL_RESET; // RULE13
    end else if (wr_control) begin
      dac_control <= hwdata[7:0] & IDACU_CONTROL_MASK; // RULE17
    end
  end

  // ==========================================================
  // Data byte holding registers; never drive the converter directly
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_data_high <= IDACU_DATA_RESET;
    end else if (wr_high) begin
      dac_data_high <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_data_low <= IDACU_DATA_RESET;
    end else if (wr_low) begin
      dac_data_low <= hwdata[7:0]; // RULE5
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bias_generator_enable <= 1'b0;
    end else if (wr_bias) begin
      bias_generator_enable <= hwdata[0];
    end
  end

  // ==========================================================
  // Event inputs come from other domains or pins; synchronise first
  // A timer level held for several cycles reloads the same word
  idacu_sync u_sync_strobe (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (external_convert_strobe),
    .sync_out (strobe_sync)
  );

  idacu_sync u_sync_t0 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (timer_overflow[0]),
    .sync_out (timer_sync_0)
  );

  idacu_sync u_sync_t1 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (timer_overflow[1]),
    .sync_out (timer_sync_1)
  );

  idacu_sync u_sync_t2 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (timer_overflow[2]),
    .sync_out (timer_sync_2)
  );

  idacu_sync u_sync_t3 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (timer_overflow[3]),
    .sync_out (timer_sync_3)
  );

  // Edge kind from source code
  assign want_rise    = (dac_update_source == IDACU_SRC_RISE) || (dac_update_source == IDACU_SRC_BOTH); // RULE16
  assign want_fall    = (dac_update_source == IDACU_SRC_FALL) || (dac_update_source == IDACU_SRC_BOTH); // RULE16

  idacu_edge u_edge_strobe (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .level_in  (strobe_sync),
    .want_rise (want_rise),
    .want_fall (want_fall),
    .edge_hit  (strobe_edge)
  );

  // ==========================================================
  // Update event selection
  always_comb begin
    unique case (dac_update_source)
      IDACU_SRC_TIMER0:  update_now = timer_sync_0; // RULE8
      IDACU_SRC_TIMER1:  update_now = timer_sync_1; // RULE8
      IDACU_SRC_TIMER2:  update_now = timer_sync_2; // RULE8
      IDACU_SRC_TIMER3:  update_now = timer_sync_3; // RULE8
      IDACU_SRC_RISE,
      IDACU_SRC_FALL,
      IDACU_SRC_BOTH:    update_now = strobe_edge; // RULE9
      IDACU_SRC_ONWRITE: update_now = 1'b0;
    endcase
  end

  assign load_latch = update_now || (onwrite_mode && wr_high); // RULE4 RULE10

  // Word assembly; a high write in on-demand mode uses the bus data directly
  always_comb begin
    if (onwrite_mode && wr_high) begin
      next_word = {hwdata[7:0], dac_data_low[7:6]}; // RULE4 RULE11
    end else begin
      next_word = {dac_data_high, dac_data_low[7:6]}; // RULE11
    end
  end

  // ==========================================================
  // Converter input latch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_latch <= IDACU_LATCH_RESET;
    end else if (load_latch) begin
      dac_latch <= next_word; // RULE10 RULE4
    end
  end

  // ==========================================================
  // Full-scale selection
  always_comb begin
    unique case (dac_fullscale_select)
      2'b00:   next_fullscale = IDACU_FS_HALF; // RULE12
      2'b01:   next_fullscale = IDACU_FS_ONE; // RULE12
      default: next_fullscale = IDACU_FS_TWO; // RULE12
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_fullscale_onehot <= IDACU_FS_TWO;
    end else begin
      dac_fullscale_onehot <= next_fullscale;
    end
  end

  // ==========================================================
  // Pin and bias control, registered for clean outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_out            <= 1'b0;
      pin_oe_b           <= 1'b1;
      pin_pullup         <= 1'b0;
      pin_analog_connect <= 1'b0;
    end else if (dac_enable) begin
      pin_out            <= 1'b0;
      pin_oe_b           <= 1'b1; // RULE1
      pin_pullup         <= 1'b0; // RULE1
      pin_analog_connect <= 1'b1; // RULE1
    end else begin
      pin_out            <= gpio_out; // RULE2
      pin_oe_b           <= gpio_oe_b; // RULE2
      pin_pullup         <= gpio_pullup; // RULE2
      pin_analog_connect <= 1'b0;
    end
  end

  // Converter power follows the enable bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_power <= 1'b0;
    end else begin
      dac_power <= dac_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bias_on <= 1'b0;
    end else begin
      bias_on <= dac_enable || bias_user_request || bias_generator_enable; // RULE3 RULE15
    end
  end

  // ==========================================================
  // Read data; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (ph_addr)
      IDACU_ADDR_CONTROL: next_rdata[7:0] = dac_control;
      IDACU_ADDR_HIGH:    next_rdata[7:0] = dac_data_high;
      IDACU_ADDR_LOW:     next_rdata[7:0] = dac_data_low;
      IDACU_ADDR_BIAS:    next_rdata[1:0] = {bias_on, bias_generator_enable};
      IDACU_ADDR_OUTPUT:  next_rdata[DATA_WIDTH-1:0] = dac_latch;
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle that ends the read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (ph_read && !hreadyout && addr_ok) begin
      hrdata <= next_rdata;
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end
endmodule // idacu_top

//--- sim/idacu_checker.sv
// Checker: port-level assertions of the DAC update control
`timescale 1ns/10ps
module idacu_checker #(
  parameter int DATA_WIDTH = 10
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  // Bus
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // Events and pin
  input wire logic [3:0]            timer_overflow,
  input wire logic                  external_convert_strobe,
  input wire logic                  bias_user_request,
  input wire logic                  gpio_out,
  input wire logic                  pin_out,
  input wire logic                  pin_oe_b,
  input wire logic                  pin_pullup,
  input wire logic                  pin_analog_connect,
  // Converter
  input wire logic [DATA_WIDTH-1:0] dac_latch,
  input wire logic                  dac_power,
  input wire logic                  bias_on,
  input wire logic [2:0]            dac_fullscale_onehot
);
  logic       data_phase;
  logic       wait_prev;
  logic [3:0] quiet_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Helpers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      data_phase <= 1'b0;
    else
      data_phase <= hsel && htrans[1] && hready;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      wait_prev <= 1'b0;
    else
      wait_prev <= !hreadyout;
  end
  // Any update cause restarts the count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      quiet_cnt <= 4'h0;
    else if (data_phase || (|timer_overflow) || $changed(external_convert_strobe))
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf)
      quiet_cnt <= quiet_cnt + 4'h1;
  end
  sequence s_enabled2;
    dac_power ##1 dac_power;
  endsequence
  // ==========================================
  // Assertions
  a_pin_analog: assert property (s_enabled2 |-> pin_analog_connect && pin_oe_b && !pin_pullup)
    else $error("pin not analog while enabled");
  a_pin_gpio: assert property ($past(rst_b) && !dac_power && !$past(dac_power) && !$past(dac_power, 2)
    |-> pin_out == $past(gpio_out) && !pin_analog_connect) else $error("pin not plain gpio");
  a_bias_enable: assert property ($rose(dac_power) |-> ##[0:1] bias_on)
    else $error("bias off while enabled");
  a_bias_user: assert property (bias_user_request |-> ##[0:2] bias_on)
    else $error("bias ignores user");
  a_scale_onehot: assert property ($onehot(dac_fullscale_onehot))
    else $error("scale select not one-hot");
  a_bus_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_read_wait: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_read_idle: assert property (!wait_prev |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_latch_quiet: assert property (quiet_cnt >= 4'h8 |-> $stable(dac_latch))
    else $error("latch moved without event");
  a_reset_value: assert property ($rose(rst_b) |-> !dac_power && dac_fullscale_onehot == 3'b100)
    else $error("wrong control reset");
endmodule  // idacu_checker

bind idacu_top idacu_checker #(.DATA_WIDTH(DATA_WIDTH)) u_checker (.clk_sys(clk_sys), .rst_b(rst_b),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer_overflow(timer_overflow), .external_convert_strobe(external_convert_strobe),
  .bias_user_request(bias_user_request), .gpio_out(gpio_out), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
  .pin_pullup(pin_pullup), .pin_analog_connect(pin_analog_connect), .dac_latch(dac_latch),
  .dac_power(dac_power), .bias_on(bias_on), .dac_fullscale_onehot(dac_fullscale_onehot));

//--- sim/idacu_partner.sv
// Partner: external strobe source
`timescale 1ns/10ps
module idacu_partner (
  // Command
  input  wire logic level_req,
  // Pin
  output logic      strobe
);
  // Off-grid edge: the pin is unrelated to the system clock
  initial strobe = 1'b0;
  always @(level_req) strobe <= #7 level_req;
endmodule  // idacu_partner

//--- sim/idacu_top_bench.sv
// Testbench: registers, update modes and pin control of the DAC update control
`timescale 1ns/10ps
module idacu_top_bench;
  import idacu_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, level_req = 1'b0;
  logic bias_req = 1'b0, gpio_out = 1'b0, gpio_oe_b = 1'b0, gpio_pullup = 1'b1;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, seed = 32'h0000_05bb;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] timer_overflow = 4'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, strobe, pin_out, pin_oe_b, pin_pullup, pin_analog_connect, dac_power, bias_on;
  logic [9:0] dac_latch;
  logic [2:0] dac_fullscale_onehot;
  int num_errors = 0, samples_checked = 0, hi, lo, lat = 0;
  always #12.5 clk_sys = ~clk_sys;
  idacu_partner u_partner (.level_req(level_req), .strobe(strobe));
  idacu_top #(.DATA_WIDTH(10)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_overflow(timer_overflow), .external_convert_strobe(strobe),
    .bias_user_request(bias_req), .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b), .gpio_pullup(gpio_pullup),
    .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_pullup(pin_pullup), .pin_analog_connect(pin_analog_connect),
    .dac_latch(dac_latch), .dac_power(dac_power), .bias_on(bias_on), .dac_fullscale_onehot(dac_fullscale_onehot));
  // ==========================================
  // Helpers
  function automatic int rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed[7:0]);
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(IDACU_ADDR_CONTROL, 1'b0, 32'h0);
    chk("control reset", rd, 32'h0000_0072);
    gpio_out <= 1'b0;
    bus(IDACU_ADDR_CONTROL, 1'b1, 32'h0000_00ff);
    bus(IDACU_ADDR_CONTROL, 1'b0, 32'h0);
    chk("control mask", rd, 32'h0000_00f3);
    chk("pin analog", {pin_analog_connect, pin_oe_b, pin_pullup, bias_on}, 32'hd);
    // Last passes write the high byte only
    for (int i = 0; i < 6; i++) begin
      lo = (i < 4) ? rnd8() : lo;
      hi = rnd8();
      if (i < 4) bus(IDACU_ADDR_LOW, 1'b1, lo);
      @(posedge clk_sys);
      chk("latch held", dac_latch, lat);
      bus(IDACU_ADDR_HIGH, 1'b1, hi);
      lat = (hi << 2) | (lo >> 6);
      @(posedge clk_sys);
      chk("latch on high", dac_latch, lat);
    end
    for (int f = 0; f < 4; f++) begin
      bus(IDACU_ADDR_CONTROL, 1'b1, 32'hf0 | f);
      repeat (2) @(posedge clk_sys);
      chk("scale", dac_fullscale_onehot, (f > 1) ? 4 : (1 << f));
    end
    // First event is a wrong timer or a rising strobe
    for (int m = 0; m < 7; m++) begin
      bus(IDACU_ADDR_CONTROL, 1'b1, 32'h82 | (m << 4));
      for (int e = 0; e < 2; e++) begin
        lo = rnd8();
        hi = rnd8();
        bus(IDACU_ADDR_LOW, 1'b1, lo);
        bus(IDACU_ADDR_HIGH, 1'b1, hi);
        repeat (8) @(posedge clk_sys);
        chk("latch waits", dac_latch, lat);
        if (m < 4) timer_overflow <= 4'h1 << (e ? m : (m + 1) % 4);
        else level_req <= ~level_req;
        @(posedge clk_sys);
        timer_overflow <= 4'h0;
        repeat (10) @(posedge clk_sys);
        if ((m < 4 && e) || (m == 4 && !e) || (m == 5 && e) || m == 6) lat = (hi << 2) | (lo >> 6);
        chk("latch event", dac_latch, lat);
      end
    end
    bus(IDACU_ADDR_OUTPUT, 1'b0, 32'h0);
    chk("latch readback", rd, lat);
    bus(IDACU_ADDR_CONTROL, 1'b1, 32'h72);
    gpio_out <= rnd8() > 127;
    repeat (3) @(posedge clk_sys);
    chk("gpio pin", {pin_out, pin_oe_b, pin_pullup, pin_analog_connect, bias_on},
      {gpio_out, gpio_oe_b, gpio_pullup, 2'b00});
    bias_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("bias user", bias_on, 32'h1);
    bias_req <= 1'b0;
    bus(IDACU_ADDR_BIAS, 1'b1, 32'h1);
    bus(IDACU_ADDR_BIAS, 1'b0, 32'h0);
    chk("bias soft", rd, 32'h3);
    bus(12'h300, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    conclude();
  end
endmodule  // idacu_top_bench
